// ==== sas_link_pkg.sv ====
package sas_link_pkg;

  // Link-rate codes, shared by the link rate and the connection rate
  typedef logic [1:0] rate_t;
  localparam rate_t RATE_1G5 = 2'h0;
  localparam rate_t RATE_3G  = 2'h1;
  localparam rate_t RATE_6G  = 2'h2;

  // Transmit dword kinds; the serializer maps each kind to its encoding
  typedef logic [3:0] tx_kind_t;
  localparam tx_kind_t TX_IDLE        = 4'h0;
  localparam tx_kind_t TX_ALIGN       = 4'h1;
  localparam tx_kind_t TX_NOTIFY      = 4'h2;
  localparam tx_kind_t TX_DATA        = 4'h3;
  localparam tx_kind_t TX_SOF         = 4'h4;
  localparam tx_kind_t TX_EOF         = 4'h5;
  localparam tx_kind_t TX_RRDY        = 4'h6;
  localparam tx_kind_t TX_ACK         = 4'h7;
  localparam tx_kind_t TX_NAK_CRC     = 4'h8;
  localparam tx_kind_t TX_DONE        = 4'h9;
  localparam tx_kind_t TX_CLOSE       = 4'hA;
  localparam tx_kind_t TX_OPEN_ACCEPT = 4'hB;
  localparam tx_kind_t TX_OPEN_REJECT = 4'hC;
  localparam tx_kind_t TX_CRED_BLOCK  = 4'hD;

  // Frame length limits in data dwords, CRC dword included
  localparam logic [8:0] FRAME_MIN_DW = 9'd7;
  localparam logic [8:0] FRAME_MAX_DW = 9'd263;

  // Credit ceiling
  localparam logic [7:0] CREDIT_MAX = 8'd255;

  // Timing
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int TIMEOUT_US     = 1000;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000000) / CLK_PERIOD_PS;

endpackage

// ==== rate_match_gen.sv ====
`timescale 1ns/1ns
// Decides per dword slot whether a rate-matching deletable primitive goes
// out, and which one, rotating the four ALIGN variants.
module rate_match_gen (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  // Rates and enable
  input  wire logic                 active,
  input  wire sas_link_pkg::rate_t  link_rate,
  input  wire sas_link_pkg::rate_t  conn_rate,
  input  wire logic                 use_notify,
  // Slot handshake
  input  wire logic                 slot,
  output logic                      insert,
  output logic                      ins_notify,
  output logic [1:0]                align_sel
);
  import sas_link_pkg::*;

  logic [1:0] phase_q, phase_d;   // Position in the 2- or 4-dword pattern
  logic [1:0] align_q, align_d;   // Next ALIGN variant
  logic       ratio2, ratio4;

  // Ratio decode; equal rates need no insertion
  always_comb begin
    ratio4 = (link_rate == RATE_6G) && (conn_rate == RATE_1G5);
    ratio2 = ((link_rate == RATE_3G) && (conn_rate == RATE_1G5)) ||
             ((link_rate == RATE_6G) && (conn_rate == RATE_3G));
  end

  // Pattern: 2:1 alternates, 4:1 inserts three of every four slots
  always_comb begin
    insert = 1'b0;
    if (active && ratio2) begin
      insert = (phase_q[0] == 1'b0);
    end else if (active && ratio4) begin
      insert = (phase_q != 2'd3);
    end
  end

  assign ins_notify = use_notify;
  assign align_sel  = align_q;

  // Next state; tolerance slots never reach here, so windows exclude them
  always_comb begin
    phase_d = phase_q;
    align_d = align_q;
    if (!active) begin
      phase_d = 2'd0;
    end else if (slot) begin
      phase_d = phase_q + 2'd1;
      if (insert && !use_notify) begin
        align_d = align_q + 2'd1;
      end
    end
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'd0;
      align_q <= 2'd0;
    end else begin
      phase_q <= phase_d;
      align_q <= align_d;
    end
  end

  // Two-to-one pattern never misses two slots in a row
  a_ratio2_window: assert property (@(posedge clock) disable iff (!arst_n)
    (active && ratio2 && slot && !insert) ##1 (active && ratio2 && slot) |-> insert)
    else $error("two plain dwords in a 2:1 window");

  // Four-to-one pattern has one plain slot per four
  a_ratio4_window: assert property (@(posedge clock) disable iff (!arst_n)
    (active && ratio4 && slot && !insert) |=> (!slot || !active || insert))
    else $error("plain dword too soon in 4:1 pattern");

  // Equal rates insert nothing
  a_equal_none: assert property (@(posedge clock) disable iff (!arst_n)
    (link_rate == conn_rate) |-> !insert)
    else $error("insert at equal rates");

  // ALIGN variant advances after each ALIGN sent
  a_align_rotate: assert property (@(posedge clock) disable iff (!arst_n)
    (slot && insert && !use_notify && active) |=> (align_sel == $past(align_sel) + 2'd1))
    else $error("ALIGN variant did not rotate");

endmodule

// ==== sas_ssp_link.sv ====
`timescale 1ns/1ns
// How it works
// - Insert deletables when link faster than connection
// - Two-to-one: one deletable per two dwords
// - Four-to-one: three deletables per four dwords
// - Tolerance deletables excluded from rate windows
// - Drop every received ALIGN and NOTIFY
// - Rotate four ALIGNs; NOTIFY may replace
// - Start matching after OPEN frame or accept
// - Idle dwords paced while awaiting response
// - Stop after CLOSE, BREAK, reply, reject
// - Send RRDY within 1 ms of accept
// - No credit possible: reject with retry
// - Initiator: no retry for outgoing wait
// - Target may retry-reject for any reason
// - Transmit and receive run independently
// - DONE when no frames; reverse primitives allowed
// - Frames framed by SOF and EOF, CRC last
// - Discard frames under 7 or over 263
// - ACK good frame within 1 ms
// - NAK on CRC, invalid dword, ERROR
// - Report NAK or ACK/NAK timeout upward
// - Credit from zero, RRDY adds, max 255
// - After DONE: timer, no frames, then CLOSE
module sas_ssp_link #(
  parameter int TIMEOUT_CYC = sas_link_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  // Rates and options
  input  wire sas_link_pkg::rate_t     link_rate,
  input  wire sas_link_pkg::rate_t     conn_rate,
  input  wire logic                    use_notify,
  input  wire logic                    port_is_target,
  // Connection control from the port layer
  input  wire logic                    open_req_in,
  input  wire logic                    open_sent,
  input  wire logic                    open_reject_rx,
  input  wire logic                    break_sent,
  input  wire logic                    buf_avail,
  input  wire logic                    need_outgoing,
  // Transmit slot and tolerance insertion from the physical side
  input  wire logic                    tx_slot,
  input  wire logic                    tol_slot,
  // Transmit frame request
  input  wire logic                    tx_frame_valid,
  input  wire logic [31:0]             tx_frame_data,
  input  wire logic                    tx_frame_last,
  output logic                         tx_frame_ready,
  input  wire logic                    tx_no_more,
  // Received dword stream
  input  wire logic                    rx_valid,
  input  wire sas_link_pkg::tx_kind_t  rx_kind,
  input  wire logic [31:0]             rx_data,
  input  wire logic                    rx_bad,
  input  wire logic                    rx_crc_ok,
  // Transmitted dword
  output sas_link_pkg::tx_kind_t       tx_kind,
  output logic [31:0]                  tx_data,
  // Received data towards the frame buffer
  output logic                         rx_dw_valid,
  output logic [31:0]                  rx_dw_data,
  // Status towards the transport layer
  output logic                         conn_open,
  output logic [7:0]                   tx_credit,
  output logic                         frame_good,
  output logic                         frame_err,
  output logic                         tx_link_err
);
  import sas_link_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE   = 4'b0001,
    C_WAIT   = 4'b0010,
    C_OPEN   = 4'b0100,
    C_CLOSE  = 4'b1000
  } conn_e;

  conn_e      conn_q, conn_d;        // Connection state
  logic       rm_q, rm_d;            // Rate matching active
  logic [7:0] credit_q, credit_d;    // Transmit credit granted by the far end
  logic       rrdy_owed_q, rrdy_owed_d;
  logic       done_tx_q, done_tx_d, done_rx_q, done_rx_d;
  logic       in_frame_q, in_frame_d;
  logic [8:0] rx_len_q, rx_len_d;
  logic       rx_err_q, rx_err_d;
  logic [1:0] ack_pend_q, ack_pend_d; // 1 = ACK, 2 = NAK owed
  logic       tx_in_frame_q, tx_in_frame_d;
  logic       eof_owed_q, eof_owed_d;    // EOF still owed; kept apart so ACK or ALIGN cannot swallow it
  logic       await_ack_q, await_ack_d;
  logic [31:0] tmr_q, tmr_d;         // Shared 1 ms timer: RRDY, ACK/NAK, DONE
  logic       good_q, good_d, err_q, err_d, lerr_q, lerr_d;
  tx_kind_t   kind_q, kind_d;
  logic [31:0] data_q, data_d;
  logic       rdw_v_q, rdw_v_d;
  logic [31:0] rdw_q, rdw_d;
  logic       rm_insert, rm_notify;
  logic [1:0] rm_align;
  logic       rm_slot, can_grant, rx_eof, len_ok;

  // A rate-matching slot is a real slot not taken by tolerance insertion
  assign rm_slot = tx_slot && !tol_slot;

  rate_match_gen u_rm (
    .clock      (clock),
    .arst_n     (arst_n),
    .active     (rm_q),
    .link_rate  (link_rate),
    .conn_rate  (conn_rate),
    .use_notify (use_notify),
    .slot       (rm_slot),
    .insert     (rm_insert),
    .ins_notify (rm_notify),
    .align_sel  (rm_align)
  );

  // Credit can be granted only with a free buffer; initiators never count
  // their own outgoing wait against that, which avoids livelock
  always_comb begin
    can_grant = buf_avail;
    if (port_is_target && need_outgoing) begin
      can_grant = 1'b0;
    end
  end

  assign rx_eof = rx_valid && (rx_kind == TX_EOF);
  assign len_ok = (rx_len_q >= FRAME_MIN_DW) && (rx_len_q <= FRAME_MAX_DW);

  // Connection, credit and frame handling
  always_comb begin
    conn_d = conn_q;
    rm_d = rm_q;
    credit_d = credit_q;
    rrdy_owed_d = rrdy_owed_q;
    done_tx_d = done_tx_q;
    done_rx_d = done_rx_q;
    in_frame_d = in_frame_q;
    rx_len_d = rx_len_q;
    rx_err_d = rx_err_q;
    ack_pend_d = ack_pend_q;
    tx_in_frame_d = tx_in_frame_q;
    eof_owed_d = eof_owed_q;
    await_ack_d = await_ack_q;
    tmr_d = (tmr_q != 32'd0) ? tmr_q - 32'd1 : 32'd0;
    good_d = 1'b0;
    err_d = 1'b0;
    lerr_d = 1'b0;
    kind_d = kind_q;
    data_d = data_q;
    rdw_v_d = 1'b0;
    rdw_d = rdw_q;
    tx_frame_ready = 1'b0;

    // Receive path runs alongside transmit
    if (rx_valid && rx_kind != TX_ALIGN && rx_kind != TX_NOTIFY) begin
      case (rx_kind)
        TX_SOF: begin
          in_frame_d = 1'b1;
          rx_len_d = 9'd0;
          rx_err_d = 1'b0;
        end
        TX_DATA: begin
          if (in_frame_q) begin
            if (rx_len_q != 9'h1FF) begin
              rx_len_d = rx_len_q + 9'd1;
            end
            rx_err_d = rx_err_q | rx_bad;
            rdw_v_d = 1'b1;
            rdw_d = rx_data;
          end
        end
        TX_EOF: begin
          in_frame_d = 1'b0;
          if (in_frame_q && len_ok) begin
            if (rx_err_q || !rx_crc_ok) begin
              ack_pend_d = 2'd2;
              err_d = 1'b1;
            end else begin
              ack_pend_d = 2'd1;
              good_d = 1'b1;
            end
          end
        end
        TX_RRDY: begin
          if (credit_q != CREDIT_MAX) begin
            credit_d = credit_q + 8'd1;
          end
        end
        TX_ACK: begin
          await_ack_d = 1'b0;
        end
        TX_NAK_CRC: begin
          await_ack_d = 1'b0;
          lerr_d = 1'b1;
        end
        TX_DONE: begin
          done_rx_d = 1'b1;
        end
        default: begin
          if (in_frame_q) begin
            rx_err_d = 1'b1;
          end
        end
      endcase
    end

    // Connection state
    case (conn_q)
      C_IDLE: begin
        if (open_req_in) begin
          credit_d = 8'd0;
          done_tx_d = 1'b0;
          done_rx_d = 1'b0;
          if (can_grant) begin
            kind_d = TX_OPEN_ACCEPT;
            conn_d = C_OPEN;
            rm_d = 1'b1;
            rrdy_owed_d = 1'b1;
            tmr_d = TIMEOUT_CYC;
          end else begin
            kind_d = TX_OPEN_REJECT;
          end
        end else if (open_sent) begin
          credit_d = 8'd0;
          done_tx_d = 1'b0;
          done_rx_d = 1'b0;
          rm_d = 1'b1;
          conn_d = C_WAIT;
        end
      end
      C_WAIT: begin
        if (open_reject_rx || break_sent) begin
          rm_d = 1'b0;
          conn_d = C_IDLE;
        end else if (rx_valid && rx_kind == TX_OPEN_ACCEPT) begin
          conn_d = C_OPEN;
          rrdy_owed_d = 1'b1;
          tmr_d = TIMEOUT_CYC;
        end
      end
      C_OPEN: begin
        if (break_sent) begin
          rm_d = 1'b0;
          conn_d = C_IDLE;
        end else if (done_tx_q && (done_rx_q || rx_kind == TX_DONE && rx_valid)) begin
          conn_d = C_CLOSE;
        end else if ((await_ack_q || done_tx_q) && tmr_q == 32'd1) begin
          lerr_d = await_ack_q;
          await_ack_d = 1'b0;
        end
      end
      C_CLOSE: begin
        conn_d = C_IDLE;
      end
      default: begin
        conn_d = C_IDLE;
      end
    endcase

    // Transmit slot: CLOSE first, then deletable, ACK/NAK, RRDY, frame dwords, SOF, DONE, then EOF
    if (tx_slot && !tol_slot && conn_q != C_IDLE) begin
      if (conn_q == C_CLOSE) begin
        kind_d = TX_CLOSE;
        rm_d = 1'b0;
      end else if (rm_insert) begin
        kind_d = rm_notify ? TX_NOTIFY : TX_ALIGN;
        data_d = {30'd0, rm_align};
      end else if (ack_pend_q != 2'd0) begin
        kind_d = (ack_pend_q == 2'd1) ? TX_ACK : TX_NAK_CRC;
        ack_pend_d = 2'd0;
      end else if (rrdy_owed_q && conn_q == C_OPEN && can_grant) begin
        kind_d = TX_RRDY;
        rrdy_owed_d = 1'b0;
      end else if (conn_q == C_OPEN && !done_tx_q && tx_in_frame_q) begin
        tx_frame_ready = tx_frame_valid;
        kind_d = tx_frame_valid ? TX_DATA : TX_IDLE;
        data_d = tx_frame_data;
        if (tx_frame_valid && tx_frame_last) begin
          tx_in_frame_d = 1'b0;
          eof_owed_d = 1'b1;
        end
      end else if (conn_q == C_OPEN && !done_tx_q && tx_frame_valid && credit_q != 8'd0 && !await_ack_q) begin
        kind_d = TX_SOF;
        tx_in_frame_d = 1'b1;
        credit_d = credit_q - 8'd1;
        await_ack_d = 1'b1;
        tmr_d = TIMEOUT_CYC;
      end else if (conn_q == C_OPEN && !done_tx_q && tx_no_more && !await_ack_q) begin
        kind_d = TX_DONE;
        done_tx_d = 1'b1;
        tmr_d = TIMEOUT_CYC;
      end else if (eof_owed_q) begin
        kind_d = TX_EOF;
        eof_owed_d = 1'b0;
      end else begin
        kind_d = TX_IDLE;
      end
    end else if (tx_slot && !tol_slot) begin
      if (conn_q == C_IDLE && !open_req_in) begin
        kind_d = TX_IDLE;
      end
    end
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conn_q <= C_IDLE;
      rm_q <= 1'b0;
      credit_q <= 8'd0;
      rrdy_owed_q <= 1'b0;
      done_tx_q <= 1'b0;
      done_rx_q <= 1'b0;
      in_frame_q <= 1'b0;
      rx_len_q <= 9'd0;
      rx_err_q <= 1'b0;
      ack_pend_q <= 2'd0;
      tx_in_frame_q <= 1'b0;
      eof_owed_q <= 1'b0;
      await_ack_q <= 1'b0;
      tmr_q <= 32'd0;
      good_q <= 1'b0;
      err_q <= 1'b0;
      lerr_q <= 1'b0;
      kind_q <= TX_IDLE;
      data_q <= 32'h0000_0000;
      rdw_v_q <= 1'b0;
      rdw_q <= 32'h0000_0000;
    end else begin
      conn_q <= conn_d;
      rm_q <= rm_d;
      credit_q <= credit_d;
      rrdy_owed_q <= rrdy_owed_d;
      done_tx_q <= done_tx_d;
      done_rx_q <= done_rx_d;
      in_frame_q <= in_frame_d;
      rx_len_q <= rx_len_d;
      rx_err_q <= rx_err_d;
      ack_pend_q <= ack_pend_d;
      tx_in_frame_q <= tx_in_frame_d;
      eof_owed_q <= eof_owed_d;
      await_ack_q <= await_ack_d;
      tmr_q <= tmr_d;
      good_q <= good_d;
      err_q <= err_d;
      lerr_q <= lerr_d;
      kind_q <= kind_d;
      data_q <= data_d;
      rdw_v_q <= rdw_v_d;
      rdw_q <= rdw_d;
    end
  end

  // Outputs
  assign tx_kind = kind_q;
  assign tx_data = data_q;
  assign rx_dw_valid = rdw_v_q;
  assign rx_dw_data = rdw_q;
  assign conn_open = (conn_q == C_OPEN);
  assign tx_credit = credit_q;
  assign frame_good = good_q;
  assign frame_err = err_q;
  assign tx_link_err = lerr_q;

  // Rejected open never opens
  a_reject_closed: assert property (@(posedge clock) disable iff (!arst_n)
    (conn_q == C_IDLE && open_req_in && !can_grant) |=> (tx_kind == TX_OPEN_REJECT && conn_q == C_IDLE))
    else $error("open accepted without credit");

  // Short frames are never acknowledged
  a_short_drop: assert property (@(posedge clock) disable iff (!arst_n)
    (rx_eof && in_frame_q && rx_len_q < FRAME_MIN_DW) |=> (ack_pend_q == $past(ack_pend_q)))
    else $error("short frame acknowledged");

  // Credit never passes the ceiling
  a_credit_cap: assert property (@(posedge clock) disable iff (!arst_n)
    (credit_q == CREDIT_MAX && conn_q == C_OPEN) |=> (credit_q >= CREDIT_MAX - 8'd1))
    else $error("credit above ceiling");

  // No frame start after DONE
  a_no_frame_done: assert property (@(posedge clock) disable iff (!arst_n)
    done_tx_q && conn_q == C_OPEN |=> tx_kind != TX_SOF)
    else $error("frame after DONE");

  // Reject stops rate matching
  a_reject_stop: assert property (@(posedge clock) disable iff (!arst_n)
    (conn_q == C_WAIT && open_reject_rx) |=> !rm_q)
    else $error("rate matching after reject");

  // Bad frame NAKed
  a_bad_nak: assert property (@(posedge clock) disable iff (!arst_n)
    (rx_eof && in_frame_q && len_ok && !rx_crc_ok) |=> (ack_pend_q == 2'd2 && frame_err))
    else $error("bad frame not NAKed");

endmodule

// ==== remote_phy.sv ====
`timescale 1ns/1ns
// Far-side phy: feeds the received dword stream and tallies our dwords
module remote_phy (
  // Clock
  input  wire logic                   clock,
  // Dwords from the block
  input  wire logic                   tx_slot,
  input  wire sas_link_pkg::tx_kind_t tx_kind,
  // Dwords towards the block
  output logic                        rx_valid,
  output sas_link_pkg::tx_kind_t      rx_kind,
  output logic [31:0]                 rx_data,
  output logic                        rx_bad,
  output logic                        rx_crc_ok
);
  import sas_link_pkg::*;
  int   seen [16];  // Dwords seen per kind
  logic slot_q;     // A fresh dword stands since the last edge

  // Deletables are only tallied like every other kind, never taken as data
  always @(posedge clock) begin
    if (slot_q === 1'b1) begin
      seen[tx_kind] = seen[tx_kind] + 1;
    end
    slot_q <= tx_slot;
  end

  // Quiet line at start
  initial begin
    rx_valid  = 1'b0;
    rx_kind   = TX_IDLE;
    rx_data   = 32'h0000_0000;
    rx_bad    = 1'b0;
    rx_crc_ok = 1'b0;
  end

  // One dword held across one edge
  task automatic put(input tx_kind_t k, input logic [31:0] d, input logic bad, input logic ok);
    rx_valid  = 1'b1;
    rx_kind   = k;
    rx_data   = d;
    rx_bad    = bad;
    rx_crc_ok = ok;
    @(posedge clock);
    #1;
  endtask

  // Release; stale data is inverted so nothing relies on a held value
  task automatic idle();
    rx_valid  = 1'b0;
    rx_kind   = TX_IDLE;
    rx_data   = ~rx_data;
    rx_bad    = 1'b0;
    rx_crc_ok = 1'b0;
  endtask

  // Frame of n data dwords, CRC last, an ALIGN slipped in mid-frame
  task automatic frame(input int n, input logic ok, input logic bad);
    put(TX_SOF, 32'h0000_0000, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      if (i == 2) begin
        put(TX_ALIGN, 32'hDEAD_0A11, 1'b0, 1'b0);
      end
      put(TX_DATA, 32'hDA7A_0000 + 32'(i), bad && (i == 3), 1'b0);
    end
    put(TX_EOF, 32'h0000_0000, 1'b0, ok);
    idle();
  endtask
endmodule

// ==== test_sas_ssp_link.sv ====
`timescale 1ns/1ns
`define CHK(g, e) check(32'(g), 32'(e))
// Self-checking bench: block against a far-side phy model
module test_sas_ssp_link;
  import sas_link_pkg::*;
  logic        clock, arst_n, use_notify, port_is_target, open_req_in, open_sent;
  logic        open_reject_rx, break_sent, buf_avail, need_outgoing, tx_slot, tol_slot;
  logic        tx_frame_valid, tx_frame_last, tx_frame_ready, tx_no_more, rx_valid;
  logic        rx_bad, rx_crc_ok, rx_dw_valid, conn_open, frame_good, frame_err, tx_link_err;
  rate_t       link_rate, conn_rate;
  tx_kind_t    rx_kind, tx_kind;
  logic [31:0] tx_frame_data, rx_data, tx_data, rx_dw_data;
  logic [7:0]  tx_credit;
  int          mismatches = 0, cmp_count = 0, good_n = 0, err_n = 0, leak = 0, lerr_n = 0;

  // Short timer so the long waits stay cheap
  sas_ssp_link #(.TIMEOUT_CYC(50)) u_sas_ssp_link (.clock, .arst_n, .link_rate, .conn_rate,
    .use_notify, .port_is_target, .open_req_in, .open_sent, .open_reject_rx, .break_sent,
    .buf_avail, .need_outgoing, .tx_slot, .tol_slot, .tx_frame_valid, .tx_frame_data,
    .tx_frame_last, .tx_frame_ready, .tx_no_more, .rx_valid, .rx_kind, .rx_data, .rx_bad,
    .rx_crc_ok, .tx_kind, .tx_data, .rx_dw_valid, .rx_dw_data, .conn_open, .tx_credit,
    .frame_good, .frame_err, .tx_link_err);
  remote_phy u_remote_phy (.clock, .tx_slot, .tx_kind, .rx_valid, .rx_kind, .rx_data,
    .rx_bad, .rx_crc_ok);

  always #2 clock = ~clock;

  // Pulse tallies and a watch for deletables leaking into the buffer
  always @(posedge clock) begin
    good_n <= good_n + 32'(frame_good === 1'b1);
    err_n  <= err_n + 32'(frame_err === 1'b1);
    lerr_n <= lerr_n + 32'(tx_link_err === 1'b1);
    leak   <= leak + 32'(rx_dw_valid === 1'b1 && rx_dw_data === 32'hDEAD_0A11);
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  // n slots, every fifth taken by tolerance and left out of the windows
  task automatic win(input int n, input int w, input int need, output int bad, output int tot);
    logic q[$];
    int   c;
    bad = 0;
    tot = 0;
    for (int i = 0; i < n; i++) begin
      tol_slot = (i % 5 == 4);
      step(1);
      if (!tol_slot) q.push_back(tx_kind === TX_ALIGN || tx_kind === TX_NOTIFY);
    end
    tol_slot = 1'b0;
    for (int i = 0; i + w <= q.size(); i++) begin
      c = 0;
      for (int j = 0; j < w; j++) c += q[i + j];
      bad += (c < need);
      tot += q[i];
    end
  endtask

  // Originating side: 2:1 pacing while waiting, silence after a reject
  task automatic t_rate21();
    int bad, tot;
    link_rate = RATE_3G;
    pulse(open_sent);
    win(24, 2, 1, bad, tot);
    `CHK(bad, 0);
    pulse(open_reject_rx);
    step(1);
    win(12, 1, 0, bad, tot);
    `CHK(tot, 0);
    $display("t_rate21 done");
  endtask

  // Reject without buffer, accept despite outgoing wait, 4:1 pacing, break
  task automatic t_open();
    int bad, tot, r0;
    link_rate  = RATE_6G;
    use_notify = 1'b1;
    pulse(open_req_in);
    `CHK(tx_kind, TX_OPEN_REJECT);
    `CHK(conn_open, 0);
    step(4);
    buf_avail     = 1'b1;
    need_outgoing = 1'b1;
    r0 = u_remote_phy.seen[TX_RRDY];
    pulse(open_req_in);
    `CHK(tx_kind, TX_OPEN_ACCEPT);
    `CHK(tx_credit, 0);
    win(40, 4, 3, bad, tot);
    `CHK(bad, 0);
    `CHK(u_remote_phy.seen[TX_RRDY] > r0, 1);
    pulse(break_sent);
    step(1);
    win(12, 1, 0, bad, tot);
    `CHK(tot, 0);
    $display("t_open done");
  endtask

  // Equal rates: no pacing; connection stays open for the later tests
  task automatic t_equal();
    int bad, tot;
    link_rate      = RATE_1G5;
    use_notify     = 1'b0;
    need_outgoing  = 1'b0;
    port_is_target = 1'b1;
    step(4);
    pulse(open_req_in);
    `CHK(tx_kind, TX_OPEN_ACCEPT);
    win(20, 1, 0, bad, tot);
    `CHK(tot, 0);
    `CHK(conn_open, 1);
    $display("t_equal done");
  endtask

  // Length bounds, then a CRC error and an invalid dword
  task automatic t_rx();
    int len [4] = '{6, 7, 263, 264};
    int a0, g0;
    for (int i = 0; i < 4; i++) begin
      a0 = u_remote_phy.seen[TX_ACK];
      g0 = good_n;
      u_remote_phy.frame(len[i], 1'b1, 1'b0);
      step(50);
      `CHK(u_remote_phy.seen[TX_ACK] - a0, i == 1 || i == 2);
      `CHK(good_n - g0, i == 1 || i == 2);
    end
    for (int i = 0; i < 2; i++) begin
      a0 = u_remote_phy.seen[TX_NAK_CRC];
      g0 = err_n;
      u_remote_phy.frame(8, i == 1, i == 1);
      step(50);
      `CHK(u_remote_phy.seen[TX_NAK_CRC] - a0, 1);
      `CHK(err_n - g0, 1);
    end
    `CHK(leak, 0);
    $display("t_rx done");
  endtask

  // Hold each dword until ready is seen at the edge
  task automatic send_tx(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      tx_frame_valid = 1'b1;
      tx_frame_data  = 32'h7E57_0000 + 32'(i);
      tx_frame_last  = (i == n - 1);
      @(negedge clock);
      for (k = 0; k < 100 && tx_frame_ready !== 1'b1; k++) @(negedge clock);
      `CHK(k < 100, 1);
      step(1);
    end
    tx_frame_valid = 1'b0;
    tx_frame_last  = 1'b0;
  endtask

  // Credit, then a frame each way at once
  task automatic t_tx();
    int s0, d0, e0, a0, l0;
    u_remote_phy.put(TX_RRDY, 32'h0000_0000, 1'b0, 1'b0);
    u_remote_phy.put(TX_RRDY, 32'h0000_0000, 1'b0, 1'b0);
    u_remote_phy.idle();
    step(2);
    `CHK(tx_credit, 2);
    s0 = u_remote_phy.seen[TX_SOF];
    d0 = u_remote_phy.seen[TX_DATA];
    e0 = u_remote_phy.seen[TX_EOF];
    a0 = u_remote_phy.seen[TX_ACK];
    l0 = lerr_n;
    fork
      send_tx(7);
      u_remote_phy.frame(7, 1'b1, 1'b0);
    join
    step(50);
    `CHK(u_remote_phy.seen[TX_SOF] - s0, 1);
    `CHK(u_remote_phy.seen[TX_DATA] - d0, 7);
    `CHK(u_remote_phy.seen[TX_EOF] - e0, 1);
    `CHK(u_remote_phy.seen[TX_ACK] - a0, 1);
    `CHK(tx_credit, 1);
    `CHK(lerr_n - l0, 1);
    $display("t_tx done");
  endtask

  // DONE when out of frames, CLOSE once DONE came back
  task automatic t_done();
    int c0;
    c0 = u_remote_phy.seen[TX_CLOSE];
    tx_no_more = 1'b1;
    step(20);
    `CHK(u_remote_phy.seen[TX_DONE] > 0, 1);
    u_remote_phy.put(TX_DONE, 32'h0000_0000, 1'b0, 1'b0);
    u_remote_phy.idle();
    step(20);
    `CHK(u_remote_phy.seen[TX_CLOSE] > c0, 1);
    $display("t_done done");
  endtask

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clock  = 1'b0;
    arst_n = 1'b0;
    {use_notify, port_is_target, open_req_in, open_sent, open_reject_rx, break_sent} = '0;
    {buf_avail, need_outgoing, tx_slot, tol_slot, tx_frame_valid, tx_frame_last} = '0;
    tx_no_more    = 1'b0;
    tx_frame_data = 32'h0000_0000;
    link_rate     = RATE_1G5;
    conn_rate     = RATE_1G5;
    step(3);
    arst_n  = 1'b1;
    tx_slot = 1'b1;
    t_rate21();
    t_open();
    t_equal();
    t_rx();
    t_tx();
    t_done();
    close_out();
  end

  // Whole run needs about 1100 cycles
  initial begin
    repeat (10000) @(posedge clock);
    mismatches++;
    close_out();
  end
endmodule
